// ===== rtl/lpsdr_mem.sv
`timescale 1ns/1ns
`default_nettype none
module lpsdr_mem
  import lpsdr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  lpsdr_if.mem LINK,
  output logic DEEP_PD,
  output logic SUSPENDED
);
  import lpsdr_pkg::*;
  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire logic sel = !LINK.cs_n;
  wire logic [2:0] cmd = {LINK.ras_n, LINK.cas_n, LINK.we_n};
  wire logic is_nop = !sel || cmd == CMD_NOP;
  wire logic is_act = sel && cmd == CMD_ACT;
  wire logic is_rd = sel && cmd == CMD_READ;
  wire logic is_wr = sel && cmd == CMD_WRITE;
  wire logic is_bst = sel && cmd == CMD_BST;
  wire logic is_pre = sel && cmd == CMD_PRE;
  wire logic is_ref = sel && cmd == CMD_REF;
  wire logic is_lmr = sel && cmd == CMD_LMR;
  wire logic ap = LINK.addr[AP_BIT];
  logic cke_prev_q;
  pwr_type pwr_q;
  bank_type bank_q [NBANK];
  logic [3:0] bcnt_q;
  logic burst_q;
  logic burst_wr_q;
  logic [BA_W-1:0] burst_bank_q;
  logic [ADDR_W-1:0] mode_q;
  localparam int COL_W = 3;
  localparam int COLS = 1 << COL_W;
  logic [DQ_W-1:0] mem_q [NBANK*COLS];
  logic [COL_W-1:0] col_q;
  logic [DQ_W-1:0] dout_q;
  logic oe_n_q;
  logic [1:0] pv_q;
  logic [DQ_W-1:0] pd_q [2];
  wire logic all_idle = bank_q[0] == BK_IDLE && bank_q[1] == BK_IDLE &&
                        bank_q[2] == BK_IDLE && bank_q[3] == BK_IDLE;
  // cke acts one edge late: a low sample freezes the next edge
  wire logic run = pwr_q == ST_RUN && cke_prev_q;
  wire logic [3:0] blen = 4'(1 << mode_q[BL_LSB +: 2]);
  wire logic [3:0] wlen = mode_q[WBM_BIT] ? 4'h1 : blen;
  wire logic [1:0] cl = mode_q[CL_LSB +: 2];
  wire logic new_acc = run && (is_rd || is_wr);
  wire logic wr_cut = new_acc && is_wr;
  wire logic beat_go = burst_q && bcnt_q != 4'h0 && !is_bst;
  wire logic rd_beat = run && (new_acc ? is_rd : beat_go && !burst_wr_q);
  wire logic wr_beat = run && (new_acc ? is_wr : beat_go && burst_wr_q);
  wire logic [COL_W-1:0] beat_col = new_acc ? LINK.addr[COL_W-1:0] : col_q;
  wire logic [BA_W-1:0] beat_bank = new_acc ? LINK.ba : burst_bank_q;
  wire logic [BA_W+COL_W-1:0] beat_at = {beat_bank, beat_col};
  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cke_prev_q <= 1'b1;
      pwr_q <= ST_RUN;
    end else begin
      cke_prev_q <= LINK.cke;
      case (pwr_q)
        ST_RUN: begin
          if (cke_prev_q && !LINK.cke) begin
            if (is_bst) pwr_q <= ST_DPD;
            else if (burst_q) pwr_q <= ST_SUSP;
            else if (is_ref && all_idle) pwr_q <= ST_SREF;
            else if (is_nop) pwr_q <= ST_PDN;
          end
        end
        ST_SUSP: if (LINK.cke) pwr_q <= ST_RUN;
        ST_PDN: if (LINK.cke && is_nop) pwr_q <= ST_RUN;
        ST_SREF: if (LINK.cke && is_nop) pwr_q <= ST_RUN;
        ST_DPD: if (LINK.cke) pwr_q <= ST_RUN;
        default: pwr_q <= ST_RUN;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // bank and burst tracking
  // ---------------------------------------------------------------
  logic [2:0] rec_q [NBANK];
  genvar g;
  for (g = 0; g < NBANK; g++) begin : g_bank
    wire logic hit = LINK.ba == BA_W'(g);
    // a newer access elsewhere ends this bank's auto precharge burst
    wire logic cut = new_acc && !hit && bank_q[g] == BK_APRE &&
                     burst_bank_q == BA_W'(g);
    always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
        bank_q[g] <= BK_IDLE;
        rec_q[g] <= 3'h0;
      end else if (run) begin
        if (cut) begin
          // read precharges at once, write waits recovery
          rec_q[g] <= burst_wr_q ? 3'(TWR_CYC + TRP_CYC)
                                 : 3'(TRP_CYC);
          bank_q[g] <= BK_PRE;
        end else if (is_act && hit && bank_q[g] == BK_IDLE) begin
          bank_q[g] <= BK_ACTIVE;
        end else if ((is_rd || is_wr) && hit && ap) begin
          bank_q[g] <= BK_APRE;
        end else if (is_pre && (hit || ap) && bank_q[g] != BK_IDLE) begin
          bank_q[g] <= BK_PRE;
          rec_q[g] <= 3'(TRP_CYC);
        end else if (bank_q[g] == BK_APRE && !(burst_q &&
                     burst_bank_q == BA_W'(g))) begin
          bank_q[g] <= BK_PRE;
          rec_q[g] <= 3'(TRP_CYC);
        end else if (bank_q[g] == BK_PRE) begin
          if (rec_q[g] == 3'h0) bank_q[g] <= BK_IDLE;
          else rec_q[g] <= rec_q[g] - 3'h1;
        end
      end
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      burst_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_bank_q <= '0;
      bcnt_q <= 4'h0;
      mode_q <= MODE_RST;
      col_q <= '0;
      pv_q <= 2'b00;
      pd_q[0] <= '0;
      pd_q[1] <= '0;
    end else if (run) begin
      // a write kills the read beats still in flight
      pv_q <= wr_cut ? 2'b00 : {pv_q[0], rd_beat};
      pd_q[0] <= mem_q[beat_at];
      pd_q[1] <= pd_q[0];
      // extended mode register (bank 2) is not modelled
      if (is_lmr && all_idle && LINK.ba == '0) mode_q <= LINK.addr;
      if (new_acc) begin
        burst_q <= 1'b1;
        burst_wr_q <= is_wr;
        burst_bank_q <= LINK.ba;
        bcnt_q <= (is_wr ? wlen : blen) - 4'h1;
        col_q <= COL_W'(LINK.addr[COL_W-1:0] + 1'b1);
      end else if (burst_q && (is_bst || bcnt_q == 4'h0)) begin
        burst_q <= 1'b0;
      end else if (burst_q) begin
        bcnt_q <= bcnt_q - 4'h1;
        col_q <= col_q + 1'b1;
      end
    end
  end
  // ---------------------------------------------------------------
  // storage; a cut write keeps what was registered before the cut
  // ---------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (wr_beat && !LINK.dqm) mem_q[beat_at] <= LINK.dq;
  end
  // ---------------------------------------------------------------
  // read data out; held while suspended
  // ---------------------------------------------------------------
  // column count wraps linearly; interleaved order is not modelled
  wire logic out_v = cl == 2'h1 ? rd_beat :
                     (cl == 2'h3 ? pv_q[1] : pv_q[0]);
  wire logic [DQ_W-1:0] out_d = cl == 2'h1 ? mem_q[beat_at] :
                                (cl == 2'h3 ? pd_q[1] : pd_q[0]);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dout_q <= '0;
      oe_n_q <= 1'b1;
      DEEP_PD <= 1'b0;
      SUSPENDED <= 1'b0;
    end else begin
      DEEP_PD <= pwr_q == ST_DPD;
      SUSPENDED <= pwr_q == ST_SUSP;
      if (run) begin
        oe_n_q <= !(out_v && !wr_cut && !LINK.dqm);
        dout_q <= out_d;
      end
    end
  end
  assign LINK.dq_mem_o = dout_q;
  assign LINK.dq_mem_oe_n = oe_n_q;
endmodule
`default_nettype wire

// ===== pkg/lpsdr_pkg.sv
`default_nettype none
package lpsdr_pkg;
  // ---------------------------------------------------------------
  // command encodings {ras_n, cas_n, we_n} with cs_n low
  // ---------------------------------------------------------------
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_BST = 3'h6;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_LMR = 3'h0;
  // ---------------------------------------------------------------
  // widths, field positions, timing
  // ---------------------------------------------------------------
  localparam int NBANK = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 12;
  localparam int DQ_W = 32;
  localparam int AP_BIT = 10;
  localparam int WBM_BIT = 9;
  localparam int BL_LSB = 0;
  localparam int CL_LSB = 4;
  localparam int CLK_NS = 4;
  localparam int DPD_HOLD_US = 100;
  localparam int DPD_HOLD_CYC = (DPD_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int DPD_WAKE_US = 200;
  localparam int DPD_WAKE_CYC = (DPD_WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int INIT_REF = 8;
  localparam int TWR_CYC = 2;
  localparam int TRP_CYC = 5;
  localparam logic [ADDR_W-1:0] MODE_RST = 12'h022;
  typedef enum logic [2:0] {
    ST_RUN = 3'h0, ST_PDN = 3'h1, ST_SREF = 3'h2, ST_SUSP = 3'h3,
    ST_DPD = 3'h4
  } pwr_type;
  typedef enum logic [1:0] {
    BK_IDLE = 2'h0, BK_ACTIVE = 2'h1, BK_APRE = 2'h2, BK_PRE = 2'h3
  } bank_type;
endpackage
`default_nettype wire

// ===== pkg/lpsdr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lpsdr_if;
  import lpsdr_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic dqm;
  logic [DQ_W-1:0] dq_ctl_o;
  logic dq_ctl_oe_n;
  logic [DQ_W-1:0] dq_mem_o;
  logic dq_mem_oe_n;
  wire [DQ_W-1:0] dq = !dq_mem_oe_n ? dq_mem_o :
                       (!dq_ctl_oe_n ? dq_ctl_o : '0);
  modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
               input dq_ctl_o, dq_ctl_oe_n, dq,
               output dq_mem_o, dq_mem_oe_n);
  modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
               output dq_ctl_o, dq_ctl_oe_n,
               input dq_mem_o, dq_mem_oe_n);
endinterface
`default_nettype wire

// ===== rtl/lpsdr_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module lpsdr_ctl
  import lpsdr_pkg::*;
#(
  parameter int HOLD_CYC = DPD_HOLD_CYC,
  parameter int WAKE_CYC = DPD_WAKE_CYC
)(
  input wire logic CLK,
  input wire logic RST,
  input wire logic REQ_VALID,
  input wire logic [2:0] REQ_CMD,
  input wire logic REQ_CKE,
  input wire logic [BA_W-1:0] REQ_BA,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DQ_W-1:0] REQ_DATA,
  input wire logic REQ_DQM,
  output logic REQ_READY,
  lpsdr_if.ctl LINK
);
  import lpsdr_pkg::*;
  // ---------------------------------------------------------------
  // wake sequencing after deep power-down
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    C_RUN = 3'h0, C_DPD = 3'h1, C_WAIT = 3'h2, C_PRE = 3'h3,
    C_REF = 3'h4, C_LMR = 3'h5, C_EMR = 3'h6
  } seq_type;
  seq_type st_q;
  logic [31:0] cnt_q;
  logic cke_q, cs_n_q, dqm_q, oe_n_q;
  logic wr_open_q;
  logic [2:0] cmd_q;
  logic [BA_W-1:0] ba_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DQ_W-1:0] dat_q;
  wire logic take = st_q == C_RUN && REQ_VALID;
  wire logic to_dpd = take && REQ_CMD == CMD_BST && !REQ_CKE;
  // nops right after a write carry the rest of its burst
  wire logic wr_data = REQ_CMD == CMD_WRITE ||
                       (REQ_CMD == CMD_NOP && wr_open_q);
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= C_RUN;
      cnt_q <= '0;
      cke_q <= 1'b1;
      cs_n_q <= 1'b1;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      addr_q <= '0;
      dqm_q <= 1'b0;
      dat_q <= '0;
      oe_n_q <= 1'b1;
      wr_open_q <= 1'b0;
    end else begin
      cs_n_q <= 1'b1;
      cmd_q <= CMD_NOP;
      oe_n_q <= 1'b1;
      wr_open_q <= 1'b0;
      case (st_q)
        C_RUN: if (take) begin
          cke_q <= REQ_CKE;
          cs_n_q <= REQ_CMD == CMD_NOP;
          cmd_q <= REQ_CMD;
          ba_q <= REQ_BA;
          addr_q <= REQ_ADDR;
          dqm_q <= REQ_DQM;
          dat_q <= REQ_DATA;
          oe_n_q <= !wr_data;
          wr_open_q <= wr_data;
          if (to_dpd) begin
            st_q <= C_DPD;
            cnt_q <= 32'(HOLD_CYC);
          end
        end
        C_DPD: begin
          if (cnt_q != 0) cnt_q <= cnt_q - 32'h1;
          else begin
            cke_q <= 1'b1;
            st_q <= C_WAIT;
            cnt_q <= 32'(WAKE_CYC);
          end
        end
        C_WAIT: begin
          if (cnt_q != 0) cnt_q <= cnt_q - 32'h1;
          else begin
            st_q <= C_PRE;
            cs_n_q <= 1'b0;
            cmd_q <= CMD_PRE;
            addr_q <= ADDR_W'(1 << AP_BIT);
            cnt_q <= 32'(TRP_CYC + INIT_REF * 8);
          end
        end
        C_PRE: begin
          cnt_q <= cnt_q - 32'h1;
          if (cnt_q[2:0] == 3'h0 && cnt_q != 0) begin
            cs_n_q <= 1'b0;
            cmd_q <= CMD_REF;
          end
          if (cnt_q == 0) st_q <= C_LMR;
        end
        C_LMR: begin
          cs_n_q <= 1'b0;
          cmd_q <= CMD_LMR;
          ba_q <= '0;
          addr_q <= MODE_RST;
          st_q <= C_EMR;
        end
        C_EMR: begin
          cs_n_q <= 1'b0;
          cmd_q <= CMD_LMR;
          ba_q <= BA_W'(2);
          addr_q <= '0;
          st_q <= C_RUN;
        end
        default: st_q <= C_RUN;
      endcase
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) REQ_READY <= 1'b0;
    else REQ_READY <= st_q == C_RUN && !to_dpd;
  end
  assign LINK.cke = cke_q;
  assign LINK.cs_n = cs_n_q;
  assign {LINK.ras_n, LINK.cas_n, LINK.we_n} = cmd_q;
  assign LINK.ba = ba_q;
  assign LINK.addr = addr_q;
  assign LINK.dqm = dqm_q;
  assign LINK.dq_ctl_o = dat_q;
  assign LINK.dq_ctl_oe_n = oe_n_q;
endmodule
`default_nettype wire

// ===== dv/lpsdr_checker.sv
`timescale 1ns/1ns
`default_nettype none
module lpsdr_checker
  import lpsdr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic dq_ctl_oe_n,
  input wire logic dq_mem_oe_n,
  input wire logic [DQ_W-1:0] dq_mem_o,
  input wire logic DEEP_PD,
  input wire logic SUSPENDED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire [2:0] cmd = {ras_n, cas_n, we_n};
  wire sel = !cs_n;
  wire run = cke && !SUSPENDED && !DEEP_PD;
  logic wake_q;
  // ---------------------------------------------------------------
  // armed in deep power-down, cleared by the first command after it
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wake_q <= 1'b0;
    end else if (DEEP_PD) begin
      wake_q <= 1'b1;
    end else if (sel) begin
      wake_q <= 1'b0;
    end
  end
  sequence s_hold; !cke [*8]; endsequence
  sequence s_quiet; cs_n [*8]; endsequence
  property p_dpd_in; sel && !cke && cmd == CMD_BST |-> ##2 DEEP_PD; endproperty
  a_dpd_in: assert property (p_dpd_in)
    else $error("no deep power-down entry");
  property p_dpd_hold; $rose(DEEP_PD) |-> s_hold; endproperty
  a_dpd_hold: assert property (p_dpd_hold)
    else $error("deep power-down left too early");
  property p_dpd_out; DEEP_PD && cke |-> ##[1:2] !DEEP_PD; endproperty
  a_dpd_out: assert property (p_dpd_out)
    else $error("deep power-down not left");
  property p_wake_quiet; $fell(DEEP_PD) |-> s_quiet; endproperty
  a_wake_quiet: assert property (p_wake_quiet)
    else $error("command during wake wait");
  property p_wake_pre;
    wake_q && !DEEP_PD && sel |-> cmd == CMD_PRE && addr[AP_BIT];
  endproperty
  a_wake_pre: assert property (p_wake_pre)
    else $error("wake does not start with precharge all");
  property p_susp_out; SUSPENDED && cke |-> ##2 !SUSPENDED; endproperty
  a_susp_out: assert property (p_susp_out)
    else $error("clock suspend not left");
  property p_susp_hold;
    SUSPENDED && $past(SUSPENDED) && !$past(dq_mem_oe_n)
      |-> !dq_mem_oe_n && $stable(dq_mem_o);
  endproperty
  a_susp_hold: assert property (p_susp_hold)
    else $error("output moved in clock suspend");
  property p_one_drv; !dq_mem_oe_n |-> dq_ctl_oe_n; endproperty
  a_one_drv: assert property (p_one_drv)
    else $error("both ends drive dq");
  property p_rd_lat;
    sel && run && cmd == CMD_READ |-> ##[2:4] !dq_mem_oe_n;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data missing");
endmodule
`default_nettype wire

// ===== dv/sdram_cke_power_and_autoprecharge_test.sv
`timescale 1ns/1ns
`default_nettype none
module sdram_cke_power_and_autoprecharge_test;
  import lpsdr_pkg::*;
  localparam logic [ADDR_W-1:0] AP = 12'h400;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic v = 1'b0;
  logic [2:0] cmd = CMD_NOP;
  logic ck = 1'b1;
  logic [BA_W-1:0] ba = '0;
  logic [ADDR_W-1:0] ad = '0;
  logic [DQ_W-1:0] wd = '0;
  logic ready;
  logic deep_pd;
  logic susp;
  logic seen = 1'b0;
  logic [DQ_W-1:0] rq[$];
  int failures = 0;
  int checked = 0;
  lpsdr_if u_lpsdr_if ();
  lpsdr_mem u_lpsdr_mem (.CLK(clk), .RST(rst), .LINK(u_lpsdr_if),
    .DEEP_PD(deep_pd), .SUSPENDED(susp));
  lpsdr_ctl #(.HOLD_CYC(10), .WAKE_CYC(10)) u_lpsdr_ctl (.CLK(clk),
    .RST(rst), .REQ_VALID(v), .REQ_CMD(cmd), .REQ_CKE(ck), .REQ_BA(ba),
    .REQ_ADDR(ad), .REQ_DATA(wd), .REQ_DQM(1'b0), .REQ_READY(ready),
    .LINK(u_lpsdr_if));
  lpsdr_checker u_lpsdr_checker (.CLK(clk), .RST(rst),
    .cke(u_lpsdr_if.cke), .cs_n(u_lpsdr_if.cs_n),
    .ras_n(u_lpsdr_if.ras_n), .cas_n(u_lpsdr_if.cas_n),
    .we_n(u_lpsdr_if.we_n), .addr(u_lpsdr_if.addr),
    .dq_ctl_oe_n(u_lpsdr_if.dq_ctl_oe_n),
    .dq_mem_oe_n(u_lpsdr_if.dq_mem_oe_n),
    .dq_mem_o(u_lpsdr_if.dq_mem_o), .DEEP_PD(deep_pd), .SUSPENDED(susp));
  always #2 clk = ~clk;
  // ---------------------------------------------------------------
  // read capture: a word held over a suspended edge is kept once
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (u_lpsdr_if.dq_mem_oe_n === 1'b0 && rq[$] !== u_lpsdr_if.dq) begin
      rq.push_back(u_lpsdr_if.dq);
    end
    if (susp === 1'b1) begin
      seen <= 1'b1;
    end
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic req(input logic [2:0] c, input logic [BA_W-1:0] b,
    input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d, input logic k);
    @(negedge clk);
    v = 1'b1;
    cmd = c;
    ba = b;
    ad = a;
    wd = d;
    ck = k;
    @(posedge clk);
    for (int n = 0; n < 300 && ready !== 1'b1; n++) @(posedge clk);
  endtask
  task automatic idle(input int n);
    @(negedge clk);
    v = 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wait_rdy(input logic l);
    for (int i = 0; i < 1000 && ready !== l; i++) @(posedge clk);
  endtask
  task automatic act(input logic [BA_W-1:0] b);
    req(CMD_ACT, b, '0, '0, 1'b1);
    idle(3);
  endtask
  task automatic wr(input logic [BA_W-1:0] b, input logic [DQ_W-1:0] d);
    req(CMD_WRITE, b, '0, d, 1'b1);
    for (int i = 1; i < 4; i++) req(CMD_NOP, b, '0, d + i, 1'b1);
    idle(4);
  endtask
  task automatic chk(input int o, input logic [31:0] b, input logic [31:0] w);
    check(32'(rq.size()), 32'(o + 4));
    check(rq[o], w);
    for (int i = 1; i < 4; i++) check(rq[o+i], b + i);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    act(2'h0);
    wr(2'h0, 32'hA0);
    rq.delete();
    req(CMD_READ, 2'h0, '0, '0, 1'b1);
    idle(8);
    chk(0, 32'hA0, 32'hA0);
    $display("test burst write done");
    act(2'h1);
    wr(2'h1, 32'hC0);
    rq.delete();
    req(CMD_READ, 2'h0, AP, '0, 1'b1);
    req(CMD_READ, 2'h1, '0, '0, 1'b1);
    idle(10);
    check(rq[0], 32'hA0);
    chk(1, 32'hC0, 32'hC0);
    $display("test concurrent auto precharge done");
    req(CMD_PRE, 2'h0, AP, '0, 1'b1);
    idle(6);
    req(CMD_PRE, 2'h0, '0, '0, 1'b1);
    req(CMD_LMR, 2'h0, MODE_RST | 12'h200, '0, 1'b1);
    idle(4);
    act(2'h0);
    wr(2'h0, 32'hB0);
    rq.delete();
    req(CMD_READ, 2'h0, '0, '0, 1'b1);
    idle(8);
    chk(0, 32'hA0, 32'hB0);
    $display("test single write done");
    rq.delete();
    req(CMD_READ, 2'h0, '0, '0, 1'b1);
    for (int i = 0; i < 5; i++) req(CMD_NOP, 2'h0, '0, '0, !(i inside {2, 3}));
    idle(8);
    check({31'h0, seen}, 32'h1);
    chk(0, 32'hA0, 32'hB0);
    $display("test clock suspend done");
    req(CMD_PRE, 2'h0, AP, '0, 1'b1);
    idle(6);
    req(CMD_BST, 2'h0, '0, '0, 1'b0);
    idle(3);
    check({31'h0, deep_pd}, 32'h1);
    ck = 1'b1;
    wait_rdy(1'b0);
    wait_rdy(1'b1);
    check({31'h0, deep_pd}, 32'h0);
    check({31'h0, ready}, 32'h1);
    $display("test deep power-down done");
    give_verdict();
  end
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
